/* inc/serial_rx_pkg.sv */
// Purpose: shared constants and types for the serial receive path
// Assumes: APB byte addresses, 32-bit words, low bits used
// Notes: all control state resets to zero
`default_nettype none
package serial_rx_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DATA = 8'h04;
    localparam logic [7:0] ADDR_MODE0 = 8'h08;
    localparam logic [7:0] ADDR_MODE1 = 8'h0c;
    localparam logic [7:0] ADDR_MODE2 = 8'h10;
    localparam logic [7:0] ADDR_FCNF = 8'h14;
    localparam logic [7:0] ADDR_RFC = 8'h18;
    // channel_control_reg fields
    localparam int CR_IOC = 0;
    localparam int CR_SCLKS = 1;
    localparam int CR_FERR = 2;
    localparam int CR_PERR = 3;
    localparam int CR_OERR = 4;
    localparam int CR_PEN = 5;
    localparam int CR_EVEN = 6;
    localparam int CR_RB8 = 7;
    // mode, fifo and level fields
    localparam int M0_MODE_LSB = 0;
    localparam int M0_RXE = 2;
    localparam int M0_WU = 3;
    localparam int M1_DPX_LSB = 0;
    localparam int M2_WBUF = 0;
    localparam int M2_RBFLL = 1;
    localparam int FC_CNFG = 0;
    localparam int FC_AUTO = 1;
    localparam int RFC_LVL_LSB = 0;
    localparam int RFC_CLR = 2;
    localparam int RFC_CNT_LSB = 4;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    // modes and depths
    localparam logic [1:0] MODE_IO = 2'h0;
    localparam logic [1:0] MODE_UART9 = 2'h3;
    localparam logic [1:0] DPX_HALF_RX = 2'h1;
    localparam logic [1:0] DPX_FULL = 2'h3;
    localparam int FIFO_DEPTH = 4;
    localparam logic [2:0] HALF_RX_DEPTH = 3'h4;
    localparam logic [2:0] FULL_DPX_DEPTH = 3'h2;
    // bit timing in serial ticks, and frame bit counts
    localparam logic [3:0] SAMPLE_PULSE = 4'h7;
    localparam logic [3:0] LAST_PULSE = 4'hf;
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam logic [3:0] NINE_BITS = 4'h9;
    localparam logic [3:0] IO_LAST_BIT = 4'h7;

    typedef struct packed {
        logic [7:0] data;
        logic ninth;
        logic perr;
        logic ferr;
    } frame_t;

    typedef enum logic [1:0] {U_IDLE, U_START, U_BITS, U_STOP} uart_state_t;
endpackage
`default_nettype wire

/* design/serial_channel_receive_path.sv */
// Purpose: receive path of a serial channel, UART or clocked I/O mode
// Assumes: serial_tick is a one-cycle pulse on pclk; pins are async
// Notes: registers over APB, zero wait states
// Contract
// - four-bit counter advances on every serial tick; code holds it at zero in UART idle and does not use it in I/O mode
// - UART bit spans sixteen ticks, sampled at the eighth
// - clock-output I/O mode samples input on clock rising edge
// - clock-input I/O mode samples on edge chosen by edge select
// - UART reception starts only after a valid start bit
// - bits shift into shift register; frame end raises receive irq
// - double buffer moves frame to buffer, sets full flag, read clears
// - FIFO takes buffer data, clears full flag, irq per fill level
// - fill level zero in half-duplex receive means four bytes
// - auto-disable clears receive enable when all storage full
// - without auto-disable reception continues as software reads FIFO
// - clock output stops when storage full; overrun meaningless there
// - single buffer halts clock per frame until buffer read
// - double buffer halts clock when shift and buffer both full
// - FIFO halts clock when all full; auto-disable clears enable
// - without FIFO next frame may arrive before buffer is read
// - parity or ninth data bit stored as ninth received bit
// - nine-bit mode unused with FIFO; parity error still reported
// - wake-up in nine-bit mode: irq only when ninth bit set
// - overrun without FIFO keeps buffer, drops shift register
// - overrun with full FIFO sets flag, keeps FIFO contents
// - UART and clock-input mode always double buffered
// - reading control register clears the three error flags
// - four-byte FIFO beside the double buffer
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module serial_channel_receive_path (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_tick,
    input wire logic serial_in_pin,
    input wire logic serial_clock_pin,
    output logic serial_clock_out,
    output logic serial_clock_oe,
    output logic receive_irq
);
    import serial_rx_pkg::*;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == ADDR_CTRL) || (a == ADDR_DATA) ||
                 (a == ADDR_MODE0) || (a == ADDR_MODE1) ||
                 (a == ADDR_MODE2) || (a == ADDR_FCNF) ||
                 (a == ADDR_RFC);
    endfunction

    logic [1:0] rxd_sync_r, sck_sync_r;
    logic sck_prev_r, rxd;
    logic ioc_r, sclks_r, pen_r, even_r, rxe_r, wu_r, wbuf_r;
    logic cnfg_r, auto_r;
    logic [1:0] mode_r, dpx_r, lvl_r;
    uart_state_t ust_r;
    logic [3:0] cnt_r, bit_cnt_r, nbits;
    logic [8:0] sh_r;
    logic done_r;
    frame_t frame_r;
    logic [7:0] buf_r, sr_data_r;
    logic buf_full_r, sr_full_r, ninth_r, sr_ninth_r;
    logic [7:0] fifo_mem [0:FIFO_DEPTH-1];
    logic [1:0] rptr_r, wptr;
    logic [2:0] fcnt_r, fcnt_nxt, depth, target;
    logic ovr_r, perr_r, ferr_r, irq_r, sck_out_r;
    logic [31:0] prdata_r, rd_mux;
    logic uart, m9, clk_out_mode, dbl, fifo_on, halt, run;
    logic rise_int, edge_in, io_sample;
    logic acc, wr, rd_setup, rd_data, rd_ctrl, fifo_clr;
    logic pop, push, buf_free, take_sr, take_new, hold, ovr, auto_clr;
    logic irq_ok;

    // pins are asynchronous to pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxd_sync_r <= 2'h3;
            sck_sync_r <= 2'h3;
            sck_prev_r <= 1'b1;
        end else begin
            rxd_sync_r <= {rxd_sync_r[0], serial_in_pin};
            sck_sync_r <= {sck_sync_r[0], serial_clock_pin};
            sck_prev_r <= sck_sync_r[1];
        end
    end
    assign rxd = rxd_sync_r[1];

    // APB decode; reads act at setup so prdata is a flop at access
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign rd_data = rd_setup && (paddr == ADDR_DATA);
    assign rd_ctrl = rd_setup && (paddr == ADDR_CTRL);
    assign fifo_clr = wr && (paddr == ADDR_RFC) && pwdata[RFC_CLR];
    assign pready = 1'b1;
    assign pslverr = acc && !mapped(paddr);
    assign prdata = prdata_r;

    // mode decode
    assign uart = (mode_r != MODE_IO);
    assign m9 = (mode_r == MODE_UART9);
    assign clk_out_mode = !uart && !ioc_r;
    assign dbl = uart || ioc_r || wbuf_r;
    assign fifo_on = cnfg_r && wbuf_r &&
                     ((dpx_r == DPX_HALF_RX) || (dpx_r == DPX_FULL));
    assign depth = (dpx_r == DPX_FULL) ? FULL_DPX_DEPTH : HALF_RX_DEPTH;
    // zero selects the full usable depth
    always_comb begin
        target = {1'b0, lvl_r};
        if (lvl_r == 2'h0 || target > depth) begin
            target = depth;
        end
    end

    // software configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ioc_r <= 1'b0;
            sclks_r <= 1'b0;
            pen_r <= 1'b0;
            even_r <= 1'b0;
            mode_r <= MODE_IO;
            wu_r <= 1'b0;
            dpx_r <= 2'h0;
            wbuf_r <= 1'b0;
            cnfg_r <= 1'b0;
            auto_r <= 1'b0;
            lvl_r <= 2'h0;
        end else if (wr) begin
            case (paddr)
                ADDR_CTRL: begin
                    ioc_r <= pwdata[CR_IOC];
                    sclks_r <= pwdata[CR_SCLKS];
                    pen_r <= pwdata[CR_PEN];
                    even_r <= pwdata[CR_EVEN];
                end
                ADDR_MODE0: begin
                    mode_r <= pwdata[M0_MODE_LSB +: 2];
                    wu_r <= pwdata[M0_WU];
                end
                ADDR_MODE1: dpx_r <= pwdata[M1_DPX_LSB +: 2];
                ADDR_MODE2: wbuf_r <= pwdata[M2_WBUF];
                ADDR_FCNF: begin
                    cnfg_r <= pwdata[FC_CNFG];
                    auto_r <= pwdata[FC_AUTO];
                end
                ADDR_RFC: lvl_r <= pwdata[RFC_LVL_LSB +: 2];
                default: ;
            endcase
        end
    end

    // receive enable; hardware clear beats a software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxe_r <= 1'b0;
        end else if (auto_clr) begin
            rxe_r <= 1'b0;
        end else if (wr && paddr == ADDR_MODE0) begin
            rxe_r <= pwdata[M0_RXE];
        end
    end

    // serial clock out; holds its level while halted
    assign halt = sr_full_r || (!dbl && buf_full_r);
    assign run = clk_out_mode && rxe_r && !halt;
    assign rise_int = run && serial_tick && !sck_out_r;
    assign serial_clock_out = sck_out_r;
    assign serial_clock_oe = clk_out_mode;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_out_r <= 1'b1;
        end else if (!clk_out_mode || !rxe_r) begin
            sck_out_r <= 1'b1;
        end else if (run && serial_tick) begin
            sck_out_r <= !sck_out_r;
        end
    end

    // sample edge for the I/O modes
    assign edge_in = sclks_r ? (sck_prev_r && !sck_sync_r[1])
                             : (!sck_prev_r && sck_sync_r[1]);
    assign io_sample = !uart && rxe_r &&
                       (ioc_r ? edge_in : rise_int);
    assign nbits = (m9 || pen_r) ? NINE_BITS : DATA_BITS;

    // frame assembly, UART and I/O share the shift register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ust_r <= U_IDLE;
            cnt_r <= 4'h0;
            bit_cnt_r <= 4'h0;
            sh_r <= 9'h000;
            done_r <= 1'b0;
            frame_r <= '0;
        end else begin
            done_r <= 1'b0;
            if (!rxe_r) begin
                ust_r <= U_IDLE;
                cnt_r <= 4'h0;
                bit_cnt_r <= 4'h0;
            end else if (!uart) begin
                if (io_sample) begin
                    sh_r[bit_cnt_r] <= rxd;
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                    if (bit_cnt_r == IO_LAST_BIT) begin
                        bit_cnt_r <= 4'h0;
                        done_r <= 1'b1;
                        frame_r <= '{data: {rxd, sh_r[6:0]},
                                     ninth: 1'b0, perr: 1'b0,
                                     ferr: 1'b0};
                    end
                end
            end else if (serial_tick) begin
                cnt_r <= cnt_r + 4'h1;
                case (ust_r)
                    U_IDLE: begin
                        cnt_r <= 4'h0;
                        // a stale count would misplace the next I/O frame
                        bit_cnt_r <= 4'h0;
                        if (!rxd) begin
                            ust_r <= U_START;
                            sh_r <= 9'h000;
                        end
                    end
                    U_START: begin
                        if (cnt_r == SAMPLE_PULSE && rxd) begin
                            ust_r <= U_IDLE;
                        end else if (cnt_r == LAST_PULSE) begin
                            ust_r <= U_BITS;
                            bit_cnt_r <= 4'h0;
                        end
                    end
                    U_BITS: begin
                        if (cnt_r == SAMPLE_PULSE) begin
                            sh_r[bit_cnt_r] <= rxd;
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end else if (cnt_r == LAST_PULSE &&
                                     bit_cnt_r == nbits) begin
                            ust_r <= U_STOP;
                        end
                    end
                    U_STOP: begin
                        if (cnt_r == SAMPLE_PULSE) begin
                            ust_r <= U_IDLE;
                            done_r <= 1'b1;
                            frame_r.data <= sh_r[7:0];
                            frame_r.ninth <= sh_r[8];
                            frame_r.perr <= pen_r && !m9 &&
                                            ((^sh_r) ^ !even_r);
                            frame_r.ferr <= !rxd;
                        end
                    end
                    default: ust_r <= U_IDLE;
                endcase
            end
        end
    end

    // storage chain: shift -> buffer -> fifo
    assign pop = rd_data && fifo_on && (fcnt_r != 3'h0);
    assign push = fifo_on && buf_full_r &&
                  ((fcnt_r < depth) || pop);
    assign buf_free = !buf_full_r || push ||
                      (rd_data && !fifo_on);
    assign take_sr = sr_full_r && buf_free;
    assign take_new = done_r && !sr_full_r && buf_free;
    assign hold = done_r && !sr_full_r && !buf_free &&
                  (clk_out_mode || (fifo_on && auto_r));
    assign ovr = done_r && !buf_free && !hold;
    assign auto_clr = hold && fifo_on && auto_r;
    assign wptr = 2'(rptr_r + fcnt_r[1:0]);
    assign fcnt_nxt = 3'(fcnt_r + {2'h0, push} - {2'h0, pop});
    assign irq_ok = !(m9 && wu_r && !frame_r.ninth);

    // buffer and pending shift word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_r <= 8'h00;
            ninth_r <= 1'b0;
            buf_full_r <= 1'b0;
            sr_full_r <= 1'b0;
            sr_data_r <= 8'h00;
            sr_ninth_r <= 1'b0;
        end else begin
            if (take_sr) begin
                buf_r <= sr_data_r;
                ninth_r <= sr_ninth_r;
                sr_full_r <= 1'b0;
            end else if (take_new) begin
                buf_r <= frame_r.data;
                ninth_r <= frame_r.ninth;
            end
            if (hold) begin
                sr_full_r <= 1'b1;
                sr_data_r <= frame_r.data;
                sr_ninth_r <= frame_r.ninth;
            end
            if (take_sr || take_new) begin
                buf_full_r <= 1'b1;
            end else if (push || (rd_data && !fifo_on)) begin
                buf_full_r <= 1'b0;
            end
        end
    end

    // receive fifo, overrun leaves it untouched
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rptr_r <= 2'h0;
            fcnt_r <= 3'h0;
        end else if (fifo_clr) begin
            rptr_r <= 2'h0;
            fcnt_r <= 3'h0;
        end else begin
            if (pop) begin
                rptr_r <= rptr_r + 2'h1;
            end
            fcnt_r <= fcnt_nxt;
        end
    end
    always_ff @(posedge pclk) begin
        if (push) begin
            fifo_mem[wptr] <= buf_r;
        end
    end

    // error flags: a new error beats the read-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovr_r <= 1'b0;
            perr_r <= 1'b0;
            ferr_r <= 1'b0;
        end else begin
            ovr_r <= ovr || (ovr_r && !rd_ctrl);
            perr_r <= (done_r && frame_r.perr) ||
                      (perr_r && !rd_ctrl);
            ferr_r <= (done_r && frame_r.ferr) ||
                      (ferr_r && !rd_ctrl);
        end
    end

    // receive event, one cycle after its cause
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else if (fifo_on) begin
            irq_r <= push && (fcnt_nxt == target) &&
                     (fcnt_r != target);
        end else begin
            irq_r <= done_r && irq_ok;
        end
    end
    assign receive_irq = irq_r;

    // read mux; data always comes through the data register
    always_comb begin
        rd_mux = RESET_WORD;
        case (paddr)
            ADDR_CTRL: begin
                rd_mux[CR_IOC] = ioc_r;
                rd_mux[CR_SCLKS] = sclks_r;
                rd_mux[CR_FERR] = ferr_r;
                rd_mux[CR_PERR] = perr_r;
                rd_mux[CR_OERR] = ovr_r;
                rd_mux[CR_PEN] = pen_r;
                rd_mux[CR_EVEN] = even_r;
                rd_mux[CR_RB8] = ninth_r;
            end
            ADDR_DATA: rd_mux[7:0] = fifo_on ? fifo_mem[rptr_r]
                                             : buf_r;
            ADDR_MODE0: begin
                rd_mux[M0_MODE_LSB +: 2] = mode_r;
                rd_mux[M0_RXE] = rxe_r;
                rd_mux[M0_WU] = wu_r;
            end
            ADDR_MODE1: rd_mux[M1_DPX_LSB +: 2] = dpx_r;
            ADDR_MODE2: begin
                rd_mux[M2_WBUF] = wbuf_r;
                rd_mux[M2_RBFLL] = buf_full_r;
            end
            ADDR_FCNF: begin
                rd_mux[FC_CNFG] = cnfg_r;
                rd_mux[FC_AUTO] = auto_r;
            end
            ADDR_RFC: begin
                rd_mux[RFC_LVL_LSB +: 2] = lvl_r;
                rd_mux[RFC_CNT_LSB +: 3] = fcnt_r;
            end
            default: rd_mux = RESET_WORD;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= RESET_WORD;
        end else if (rd_setup) begin
            prdata_r <= rd_mux;
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_tick_count: assert property (ust_r == U_BITS && serial_tick && rxe_r
        |=> cnt_r == 4'($past(cnt_r) + 4'h1))
        else $error("counter did not advance on tick");
    a_sample_point: assert property (uart && ust_r == U_BITS &&
        bit_cnt_r != $past(bit_cnt_r) |-> $past(cnt_r) == SAMPLE_PULSE &&
        $past(serial_tick))
        else $error("uart bit taken off the eighth pulse");
    a_false_start: assert property (ust_r == U_START && serial_tick &&
        rxe_r && cnt_r == SAMPLE_PULSE && rxd |=> ust_r == U_IDLE)
        else $error("false start bit not rejected");
    a_frame_irq: assert property (done_r && !fifo_on && irq_ok
        |=> receive_irq ##1 !receive_irq)
        else $error("frame end gave no single irq pulse");
    a_wake_mask: assert property (done_r && !fifo_on && m9 && wu_r &&
        !frame_r.ninth |=> !receive_irq)
        else $error("irq raised with ninth bit clear");
    a_flag_read: assert property (buf_full_r && rd_data && !fifo_on &&
        !take_sr && !take_new |=> !buf_full_r)
        else $error("buffer full flag not cleared by read");
    a_fifo_drain: assert property (push && !pop && !fifo_clr
        |=> fcnt_r == 3'($past(fcnt_r) + 3'h1))
        else $error("buffer word not moved into fifo");
    a_clock_halt: assert property (clk_out_mode && halt
        |=> $stable(serial_clock_out) || !rxe_r)
        else $error("serial clock moved while halted");
    a_ovr_keep: assert property (ovr |=> ovr_r && $stable(buf_r) &&
        $stable(fcnt_r) || $past(fifo_clr))
        else $error("overrun lost flag or stored data");
    a_auto_off: assert property (auto_clr |=> !rxe_r [*2])
        else $error("receive enable not cleared when full");
    a_err_clear: assert property (rd_ctrl && !done_r && !ovr
        |=> !ovr_r && !perr_r && !ferr_r)
        else $error("error flags survived control read");

    c_uart_frame: cover property (uart && done_r && take_new);
    c_overrun: cover property (ovr);
    c_auto_stop: cover property (auto_clr);
    c_clock_resume: cover property (clk_out_mode && halt ##1 !halt);
endmodule // serial_channel_receive_path
`default_nettype wire

/* verification/serial_peer.sv */
// Purpose: remote sender that drives the receive pins
// Assumes: ticks are one-cycle pulses on pclk
// Notes: line idles high; link clock idles high
`timescale 1ns/100ps
`default_nettype none
module serial_peer (
    input wire logic pclk,
    input wire logic serial_tick,
    input wire logic dclk,
    output logic line,
    output logic sclk
);
    initial begin
        line = 1'b1;
        sclk = 1'b1;
    end
    // one bit time is sixteen ticks
    task automatic bit_out(input logic v);
        line <= v;
        repeat (16) @(posedge pclk iff serial_tick);
    endtask
    // start bit, data lsb first, then stop bit
    task automatic send_uart(input logic [8:0] d, input int n);
        bit_out(1'b0);
        for (int i = 0; i < n; i++) bit_out(d[i]);
        bit_out(1'b1);
    endtask
    // link clock stands still outside the frame
    task automatic send_io(input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            #80 sclk = 1'b0;
            line = d[i];
            #80 sclk = 1'b1;
        end
        #80 line = ~d[7]; // released: no stale level
    endtask
    // low pulse far shorter than half a bit
    task automatic glitch();
        line <= 1'b0;
        repeat (4) @(posedge pclk iff serial_tick);
        line <= 1'b1;
        repeat (32) @(posedge pclk iff serial_tick);
    endtask
    // follow the block's own clock: new bit after each fall
    task automatic answer_io(input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            @(negedge dclk);
            line = d[i];
        end
        @(posedge dclk);
        line = ~d[7];
    endtask
endmodule // serial_peer
`default_nettype wire

/* verification/test_serial_channel_receive_path.sv */
// Purpose: self-checking bench for the serial receive path
// Assumes: zero-wait APB, tick every fourth cycle
// Notes: reads queue their expectation for the monitor
`timescale 1ns/100ps
`default_nettype none
module test_serial_channel_receive_path;
    import serial_rx_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, serial_tick;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, sin, sclk, irq, sco, soe;
    int bad_count, checked, irq_seen, tk, n, falls;
    logic [64:0] exp_q[$];
    logic [64:0] e;
    logic [8:0] b, c;
    logic [7:0] regs [6] = '{ADDR_CTRL, ADDR_MODE0, ADDR_MODE1,
        ADDR_MODE2, ADDR_FCNF, ADDR_RFC};
    serial_channel_receive_path u_serial_channel_receive_path (
        .pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_tick(serial_tick),
        .serial_in_pin(sin), .serial_clock_pin(sclk),
        .serial_clock_out(sco), .serial_clock_oe(soe), .receive_irq(irq));
    serial_peer u_serial_peer (.pclk(pclk), .serial_tick(serial_tick),
        .dclk(sco), .line(sin), .sclk(sclk));
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // tick pulse, irq pulse count
    always @(posedge pclk) begin
        tk <= (tk + 1) % 4;
        serial_tick <= (tk == 3);
        if (irq === 1'b1) irq_seen <= irq_seen + 1;
    end
    // falls of the driven serial clock
    always @(negedge sco) falls++;
    task automatic chk_word(input logic [31:0] g, x, input string m);
        checked++;
        if (g !== x) begin
            bad_count++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    task automatic chk_bit(input logic g, x, input string m);
        checked++;
        if (g !== x) begin
            bad_count++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    // monitor: oldest note against each read answer
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = exp_q.pop_front();
            chk_word(prdata & e[63:32], e[31:0], "read data");
            chk_bit(pslverr, e[64], "slave error");
        end
    end
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, m,
        input logic er);
        exp_q.push_back({er, m, x});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic chk_irq(input int k);
        repeat (8) @(posedge pclk);
        chk_word(irq_seen, k, "irq count");
    endtask
    task automatic close_out();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #1000000;
        bad_count++;
        close_out();
    end
    initial begin
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        void'($urandom(17));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        foreach (regs[i]) rd(regs[i], RESET_WORD, '1, 1'b0);
        rd(8'h1c, 32'h0, '1, 1'b1); // unmapped
        // 8-bit uart, double buffer on
        apb(1'b1, ADDR_MODE2, 32'h1);
        apb(1'b1, ADDR_MODE0, 32'h5);
        u_serial_peer.glitch();
        chk_irq(0);
        rd(ADDR_MODE2, 32'h0, 32'h2, 1'b0);
        b = 9'($urandom());
        c = 9'($urandom());
        u_serial_peer.send_uart(b, 8);
        chk_irq(1);
        rd(ADDR_MODE2, 32'h2, 32'h2, 1'b0);
        rd(ADDR_DATA, {24'h0, b[7:0]}, 32'hff, 1'b0);
        rd(ADDR_MODE2, 32'h0, 32'h2, 1'b0);
        // three more frames with no read between
        u_serial_peer.send_uart(b, 8);
        u_serial_peer.send_uart(c, 8);
        u_serial_peer.send_uart(c, 8);
        rd(ADDR_CTRL, 32'h10, 32'h10, 1'b0);
        rd(ADDR_DATA, {24'h0, b[7:0]}, 32'hff, 1'b0);
        rd(ADDR_CTRL, 32'h0, 32'h10, 1'b0);
        // even parity, wrong parity bit sent
        apb(1'b1, ADDR_CTRL, 32'h60);
        u_serial_peer.send_uart({~^b[7:0], b[7:0]}, 9);
        rd(ADDR_CTRL, {24'h0, ~^b[7:0], 7'h08}, 32'h88, 1'b0);
        rd(ADDR_DATA, {24'h0, b[7:0]}, 32'hff, 1'b0);
        // 9-bit wake-up: only ninth bit set interrupts
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_MODE0, 32'hf);
        n = irq_seen;
        u_serial_peer.send_uart({1'b0, b[7:0]}, 9);
        chk_irq(n);
        rd(ADDR_DATA, {24'h0, b[7:0]}, 32'hff, 1'b0);
        u_serial_peer.send_uart({1'b1, c[7:0]}, 9);
        chk_irq(n + 1);
        rd(ADDR_CTRL, 32'h80, 32'h80, 1'b0);
        rd(ADDR_DATA, {24'h0, c[7:0]}, 32'hff, 1'b0);
        // fifo of four: one irq at four bytes, read back in order
        apb(1'b1, ADDR_MODE0, 32'h5);
        apb(1'b1, ADDR_MODE1, 32'h1);
        apb(1'b1, ADDR_FCNF, 32'h1);
        n = irq_seen;
        repeat (2) begin
            u_serial_peer.send_uart(b, 8);
            u_serial_peer.send_uart(c, 8);
        end
        chk_irq(n + 1);
        rd(ADDR_RFC, 32'h40, 32'h70, 1'b0);
        repeat (2) begin
            rd(ADDR_DATA, {24'h0, b[7:0]}, 32'hff, 1'b0);
            rd(ADDR_DATA, {24'h0, c[7:0]}, 32'hff, 1'b0);
        end
        apb(1'b1, ADDR_FCNF, 32'h0);
        // clocked i/o, clock input, rising edge; edge select first
        apb(1'b1, ADDR_CTRL, 32'h1);
        apb(1'b1, ADDR_MODE0, 32'h4);
        n = irq_seen;
        u_serial_peer.send_io(c[7:0]);
        chk_irq(n + 1);
        chk_bit(soe, 1'b0, "clock drive");
        rd(ADDR_DATA, {24'h0, c[7:0]}, 32'hff, 1'b0);
        // clocked i/o, own clock out, single buffer halts per frame
        apb(1'b1, ADDR_MODE0, 32'h0);
        apb(1'b1, ADDR_MODE2, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_MODE0, 32'h4);
        u_serial_peer.answer_io(b[7:0]);
        repeat (8) @(posedge pclk);
        chk_bit(soe, 1'b1, "clock drive");
        n = falls;
        repeat (40) @(posedge pclk);
        chk_word(falls, n, "clock halt");
        rd(ADDR_DATA, {24'h0, b[7:0]}, 32'hff, 1'b0);
        repeat (16) @(posedge pclk);
        chk_bit(falls != n, 1'b1, "clock resume");
        close_out();
    end
endmodule // test_serial_channel_receive_path
`default_nettype wire
